/* File: pkg/vlt_pkg.sv */
// constants, types and register layout of the variable length timer core
package vlt_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] COUNT_OFFSET   = 8'h04;
    localparam logic [7:0] STATUS_OFFSET  = 8'h08;
    localparam logic [7:0] BUFFER_BASE    = 8'h10;
    localparam logic [7:0] LATCH_BASE     = 8'h20;
    localparam int         CHANNELS       = 3;  // channel 0 is the period channel

    // ==========================================================
    // count ceilings per length
    localparam logic [15:0] CEILING_16 = 16'hFFFF;
    localparam logic [15:0] CEILING_12 = 16'h0FFF;
    localparam logic [15:0] CEILING_10 = 16'h03FF;
    localparam logic [15:0] CEILING_8  = 16'h00FF;

    // ==========================================================
    // status bit positions
    localparam int MATCH_BIT = 0;
    localparam int WRAP_BIT  = 1;
    localparam int DOWN_BIT  = 2;

    // ==========================================================
    // field encodings
    typedef enum logic [1:0] {
        MODE_STOP       = 2'b00,
        MODE_UP         = 2'b01,
        MODE_CONTINUOUS = 2'b10,
        MODE_UP_DOWN    = 2'b11
    } mode_select_field_t;

    typedef enum logic [1:0] {
        LEN_16 = 2'b00,
        LEN_12 = 2'b01,
        LEN_10 = 2'b10,
        LEN_8  = 2'b11
    } length_t;

    typedef enum logic [1:0] {
        LOAD_IMMEDIATE = 2'b00,
        LOAD_AT_ZERO   = 2'b01,
        LOAD_AT_TURN   = 2'b10,
        LOAD_AT_ZERO_B = 2'b11
    } load_event_t;

    // control word, bit 0 upward: clear, source, divider, mode, length, enables
    typedef struct packed {
        logic [16:0]        reserved;
        logic               latch_group;
        load_event_t        load_event;
        logic               global_irq_enable;
        logic               match_irq_enable;
        logic               wrap_irq_enable;
        length_t            length;
        mode_select_field_t mode_select_field;
        logic [1:0]         divider_select;
        logic [1:0]         source_select;
        logic               counter_clear_bit;
    } timer_control_word_t;

    localparam timer_control_word_t CONTROL_RESET = 32'h0000_0000;

    // apb carriers
    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage

/* File: rtl/variable_length_timer_core.sv */
// counter core of a variable length timer with apb register access
`timescale 1ns/100ps
`default_nettype none

module variable_length_timer_core
    import vlt_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire vlt_pkg::apb_req_t apb_req,
    output vlt_pkg::apb_rsp_t    apb_rsp,
    input  wire logic            external_timer_clock,
    input  wire logic            auxiliary_clock,
    input  wire logic            master_clock,
    input  wire logic            sub_system_clock,
    output logic [CHANNELS-1:0]  compare_equal,
    output logic                 irq_request
);
    import vlt_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [3:0]                 sync1;
        logic [3:0]                 sync2;
        logic [3:0]                 sync3;
        logic [2:0]                 div_cnt;
        logic [15:0]                count_value;
        logic                       count_down;
        logic                       zero_halt;
        timer_control_word_t        ctrl;
        logic                       period_match_flag;
        logic                       wrap_flag;
        logic [CHANNELS-1:0][15:0]  compare_buffer_n;
        logic [CHANNELS-1:0][15:0]  compare_latch_n;
        logic [CHANNELS-1:0]        pending;
        logic [CHANNELS-1:0]        equal;
        logic [31:0]                prdata;
        logic                       pslverr;
    } state_t;

    state_t state;
    state_t next_state;

    // ==========================================================
    // next state
    always_comb
    begin
        logic [3:0]  src_rise;
        logic        tick;
        logic [2:0]  div_mask;
        logic [15:0] ceiling;
        logic [15:0] period;
        logic [15:0] cnt;
        logic        set_match;
        logic        set_wrap;
        logic        ev_zero;
        logic        ev_turn;
        logic        load_now;
        logic        all_pending;
        logic        wr;
        logic        setup;
        logic [31:0] rdata;
        logic        hit;
        logic [31:0] wdata;
        src_rise    = 4'h0;
        tick        = 1'b0;
        div_mask    = 3'h0;
        ceiling     = CEILING_16;
        period      = 16'h0000;
        cnt         = 16'h0000;
        set_match   = 1'b0;
        set_wrap    = 1'b0;
        ev_zero     = 1'b0;
        ev_turn     = 1'b0;
        load_now    = 1'b0;
        all_pending = 1'b0;
        wr          = 1'b0;
        setup       = 1'b0;
        rdata       = 32'h0000_0000;
        hit         = 1'b0;
        wdata       = apb_req.pwdata;
        next_state  = state;

        // clock sources pass two flops; the third only feeds the edge detector
        next_state.sync1 = {sub_system_clock, master_clock, auxiliary_clock,
                            external_timer_clock};
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        src_rise         = state.sync2 & ~state.sync3;

        // input divider: a tick each 1, 2, 4 or 8 source edges
        unique case (state.ctrl.divider_select)
            2'b00: div_mask = 3'h0;
            2'b01: div_mask = 3'h1;
            2'b10: div_mask = 3'h3;
            2'b11: div_mask = 3'h7;
        endcase
        if (src_rise[state.ctrl.source_select])
        begin
            next_state.div_cnt = state.div_cnt + 3'h1;
            tick = ((state.div_cnt & div_mask) == div_mask);
        end

        // ceiling per length
        unique case (state.ctrl.length)
            LEN_16: ceiling = CEILING_16;
            LEN_12: ceiling = CEILING_12;
            LEN_10: ceiling = CEILING_10;
            LEN_8:  ceiling = CEILING_8;
        endcase

        period = state.compare_latch_n[0];
        cnt    = state.count_value & ceiling;

        // counter stepping on each timer tick; stop mode simply holds
        if (tick && state.ctrl.mode_select_field != MODE_STOP)
        begin
            unique case (state.ctrl.mode_select_field)
                MODE_CONTINUOUS:
                begin
                    if (cnt >= ceiling)
                    begin
                        next_state.count_value = 16'h0000;
                        set_wrap = 1'b1;
                        ev_zero  = 1'b1;
                    end
                    else
                    begin
                        next_state.count_value = cnt + 16'h0001;
                    end
                end
                MODE_UP, MODE_UP_DOWN:
                begin
                    if (period == 16'h0000)
                    begin
                        next_state.zero_halt = 1'b1;
                    end
                    else if (state.zero_halt)
                    begin
                        next_state.zero_halt   = 1'b0;
                        next_state.count_value = 16'h0000;
                        next_state.count_down  = 1'b0;
                    end
                    else if (period > ceiling)
                    begin
                        if (state.ctrl.mode_select_field == MODE_UP)
                        begin
                            next_state.count_value = 16'h0000;
                            ev_zero = 1'b1;
                        end
                        else if (cnt >= ceiling)
                        begin
                            next_state.count_value = 16'h0000;
                            next_state.count_down  = 1'b0;
                            set_wrap = 1'b1;
                            ev_zero  = 1'b1;
                        end
                        else
                        begin
                            next_state.count_value = cnt + 16'h0001;
                        end
                    end
                    else if (state.ctrl.mode_select_field == MODE_UP)
                    begin
                        if (cnt >= period)
                        begin
                            next_state.count_value = 16'h0000;
                            set_wrap = (cnt == period);
                            ev_zero  = 1'b1;
                        end
                        else
                        begin
                            next_state.count_value = cnt + 16'h0001;
                            set_match = (cnt + 16'h0001 == period);
                        end
                    end
                    else if (!state.count_down)
                    begin
                        if (cnt >= period)
                        begin
                            next_state.count_down  = 1'b1;
                            next_state.count_value = cnt - 16'h0001;
                            ev_turn = 1'b1;
                        end
                        else
                        begin
                            next_state.count_value = cnt + 16'h0001;
                            set_match = (cnt + 16'h0001 == period);
                        end
                    end
                    else if (cnt == 16'h0000)
                    begin
                        next_state.count_down  = 1'b0;
                        next_state.count_value = 16'h0001;
                    end
                    else
                    begin
                        next_state.count_value = cnt - 16'h0001;
                        if (cnt == 16'h0001)
                        begin
                            next_state.count_down = 1'b0;
                            set_wrap = 1'b1;
                            ev_zero  = 1'b1;
                        end
                    end
                end
                default:
                begin
                    next_state.count_value = cnt;
                end
            endcase
        end

        // apb: a write lands at the access edge, read data is caught at setup
        wr    = apb_req.psel & apb_req.penable & apb_req.pwrite;
        setup = apb_req.psel & ~apb_req.penable;

        if (wr && apb_req.paddr == CONTROL_OFFSET)
        begin
            next_state.ctrl = timer_control_word_t'({17'h00000, wdata[14:1], 1'b0});
        end
        if (wr && apb_req.paddr == COUNT_OFFSET)
        begin
            // a plain load never sets a flag
            next_state.count_value = wdata[15:0] & ceiling;
            next_state.zero_halt   = 1'b0;
            set_wrap  = 1'b0;
            set_match = 1'b0;
        end

        // clear bit: count, divider and direction memory go back to zero
        if (wr && apb_req.paddr == CONTROL_OFFSET && wdata[0])
        begin
            next_state.count_value = 16'h0000;
            next_state.div_cnt     = 3'h0;
            next_state.count_down  = 1'b0;
            next_state.zero_halt   = 1'b0;
        end

        // flags: write one to clear, but a same-cycle set wins
        if (wr && apb_req.paddr == STATUS_OFFSET)
        begin
            next_state.period_match_flag = state.period_match_flag & ~wdata[MATCH_BIT];
            next_state.wrap_flag         = state.wrap_flag & ~wdata[WRAP_BIT];
        end
        next_state.period_match_flag = next_state.period_match_flag | set_match;
        next_state.wrap_flag         = next_state.wrap_flag | set_wrap;

        // buffer writes mark a pending transfer into the latch
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (wr && apb_req.paddr == BUFFER_BASE + 8'(4 * i))
            begin
                next_state.compare_buffer_n[i] = wdata[15:0];
                next_state.pending[i]          = 1'b1;
            end
        end

        // transfer event; immediate mode is the reset value
        unique case (state.ctrl.load_event)
            LOAD_IMMEDIATE: load_now = 1'b1;
            LOAD_AT_ZERO:   load_now = ev_zero;
            LOAD_AT_TURN:   load_now = ev_zero | ev_turn;
            LOAD_AT_ZERO_B: load_now = ev_zero;
        endcase
        all_pending = &state.pending;
        for (int i = 0; i < CHANNELS; i++)
        begin
            // a group only moves when every member has fresh data
            if (state.pending[i] && load_now
                && (!state.ctrl.latch_group || all_pending))
            begin
                next_state.compare_latch_n[i] = state.compare_buffer_n[i];
                next_state.pending[i]         = next_state.pending[i]
                                                & (wr && apb_req.paddr == BUFFER_BASE
                                                   + 8'(4 * i));
            end
            next_state.equal[i] = ((next_state.count_value & ceiling)
                                   == next_state.compare_latch_n[i]);
        end

        // read mux; unmapped addresses answer with an error
        hit = 1'b1;
        if (apb_req.paddr == CONTROL_OFFSET)
        begin
            rdata = 32'(state.ctrl);
        end
        else if (apb_req.paddr == COUNT_OFFSET)
        begin
            rdata = {16'h0000, cnt};
        end
        else if (apb_req.paddr == STATUS_OFFSET)
        begin
            rdata = {29'h0000_0000, state.count_down, state.wrap_flag,
                     state.period_match_flag};
        end
        else
        begin
            hit = 1'b0;
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (apb_req.paddr == BUFFER_BASE + 8'(4 * i))
                begin
                    rdata = {16'h0000, state.compare_buffer_n[i]};
                    hit   = 1'b1;
                end
                if (apb_req.paddr == LATCH_BASE + 8'(4 * i))
                begin
                    rdata = {16'h0000, state.compare_latch_n[i]};
                    hit   = 1'b1;
                end
            end
        end
        if (setup)
        begin
            next_state.prdata  = rdata;
            next_state.pslverr = ~hit;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state      <= '0;
            state.ctrl <= CONTROL_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    // zero wait states: read data was captured in the setup cycle
    assign apb_rsp.prdata  = state.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = state.pslverr & apb_req.psel & apb_req.penable;
    assign compare_equal   = state.equal;
    // request only when flag, its own enable and the global enable agree
    assign irq_request = state.ctrl.global_irq_enable
                         & ((state.period_match_flag & state.ctrl.match_irq_enable)
                            | (state.wrap_flag & state.ctrl.wrap_irq_enable));

endmodule

`default_nettype wire

/* File: tb/vlt_core_chk.sv */
// assertion checker for the variable length timer core
`timescale 1ns/100ps
`default_nettype none
module vlt_core_chk
    import vlt_pkg::*;
(
    input wire logic                clock,
    input wire logic                rst_n,
    input wire vlt_pkg::apb_req_t   apb_req,
    input wire vlt_pkg::apb_rsp_t   apb_rsp,
    input wire logic                external_timer_clock,
    input wire logic                auxiliary_clock,
    input wire logic                master_clock,
    input wire logic                sub_system_clock,
    input wire logic [CHANNELS-1:0] compare_equal,
    input wire logic                irq_request
);
    logic [31:0] ctl_q;
    logic [15:0] ceil;
    logic        acc;
    logic        rd;
    logic        mapped;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // shadow of the control word, updated at the write commit edge
    assign acc = apb_req.psel && apb_req.penable;
    assign rd = acc && !apb_req.pwrite;
    assign mapped = apb_req.paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
                                          8'h20, 8'h24, 8'h28};
    assign ceil = (ctl_q[8:7] == LEN_8) ? CEILING_8 : (ctl_q[8:7] == LEN_10) ? CEILING_10 :
                  (ctl_q[8:7] == LEN_12) ? CEILING_12 : CEILING_16;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ctl_q <= 32'h0;
        else if (acc && apb_req.pwrite && apb_req.paddr == CONTROL_OFFSET)
            ctl_q <= apb_req.pwdata;
    end

    // ==========================================================
    // bus, request and compare relations
    a_ready_always: assert property (acc |-> apb_rsp.pready)
        else $error("pready low in access phase");
    a_err_unmapped: assert property (acc && !mapped |-> apb_rsp.pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (acc && mapped |-> !apb_rsp.pslverr)
        else $error("error on mapped access");
    a_err_idle: assert property (!acc |-> !apb_rsp.pslverr)
        else $error("error outside access phase");
    a_rdata_hold: assert property (rd ##1 !apb_req.psel |-> $stable(apb_rsp.prdata))
        else $error("read data moved after access");
    a_irq_reset: assert property (!$past(rst_n) |-> !irq_request)
        else $error("request right after reset");
    // request may lag the enable by one cycle if the output is registered
    a_irq_global: assert property (irq_request |-> ctl_q[11] || $past(ctl_q[11]))
        else $error("request without global enable");
    a_irq_enable: assert property (irq_request |-> |ctl_q[10:9] || |$past(ctl_q[10:9]))
        else $error("request without source enable");
    a_ctrl_read: assert property (rd && apb_req.paddr == CONTROL_OFFSET
        |-> apb_rsp.prdata[14:0] == {ctl_q[14:1], 1'b0})
        else $error("control read differs from written word");
    a_count_mask: assert property (rd && apb_req.paddr == COUNT_OFFSET
        |-> (apb_rsp.prdata & ~{16'h0, ceil}) == 32'h0)
        else $error("count has bits above its length");
    a_cmp_reset: assert property ($past(rst_n) && !$past(rst_n, 2)
        |-> compare_equal == '1)
        else $error("compare outputs not all equal after reset");

    c_unmapped: cover property (acc && !mapped);
    c_irq: cover property (irq_request);
    c_cmp: cover property ($rose(compare_equal[1]));
endmodule

bind variable_length_timer_core vlt_core_chk chk (
    .clock(clock), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .external_timer_clock(external_timer_clock), .auxiliary_clock(auxiliary_clock),
    .master_clock(master_clock), .sub_system_clock(sub_system_clock),
    .compare_equal(compare_equal), .irq_request(irq_request)
);
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the variable length timer core
`timescale 1ns/100ps
`default_nettype none
module tb;
    import vlt_pkg::*;
    logic                clock;
    logic                rst_n;
    apb_req_t            req;
    apb_rsp_t            rsp;
    logic [3:0]          src = 4'h0;
    logic [CHANNELS-1:0] ceq;
    logic                irq;
    logic [31:0]         rd;
    logic [31:0]         cfg;
    logic                er;
    logic [7:0]          cyc = 8'h00;
    logic [15:0]         ceil_t [4];
    int                  sel;
    int                  err_count;
    int                  checks;

    variable_length_timer_core dut (
        .clock(clock), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .external_timer_clock(src[0]), .auxiliary_clock(src[1]),
        .master_clock(src[2]), .sub_system_clock(src[3]),
        .compare_equal(ceq), .irq_request(irq)
    );

    always #2.5 clock = ~clock;

    // only the selected source runs, period 16 cycles, so a wrong pick gives no ticks
    always @(posedge clock)
    begin
        cyc <= cyc + 8'h01;
        src <= cyc[3] ? 4'(1 << sel) : 4'h0;
    end

    // ==========================================================
    // bus and compare tasks
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge clock);
        req.penable <= 1'b1;
        @(posedge clock);
        // only the watchdog may end a wait for pready
        while (rsp.pready !== 1'b1)
        begin
            @(posedge clock);
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, rd);
    endtask

    // irq may be registered, so look a little after the write settles
    task automatic irqchk(input logic e);
        repeat (2) @(posedge clock);
        #1;
        chk("irq_request", {31'h0, e}, {31'h0, irq});
        @(posedge clock);
    endtask

    function automatic logic [31:0] cw(input logic [1:0] l, d, s, input logic [5:0] hi);
        return {17'h0, hi, l, 2'b00, d, s, 1'b0};
    endfunction

    // start a mode clear of source edges, let n edges tick, then halt again
    task automatic go(input logic [1:0] m, input int n);
        @(posedge cyc[3]);
        repeat (8) @(posedge clock);
        wr(CONTROL_OFFSET, cfg | {25'h0, m, 5'h0});
        repeat (n) @(posedge cyc[3]);
        repeat (9) @(posedge clock);
        wr(CONTROL_OFFSET, cfg);
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // watchdog, far beyond the few thousand cycles the tests need
    initial
    begin
        repeat (60000) @(posedge clock);
        err_count++;
        final_report;
    end

    // ==========================================================
    // test sequence
    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        req = '0;
        sel = 0;
        err_count = 0;
        checks = 0;
        ceil_t = '{CEILING_16, CEILING_12, CEILING_10, CEILING_8};
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rc(CONTROL_OFFSET, 32'h0, "control");
        rc(STATUS_OFFSET, 32'h0, "status");
        chk("compare_equal", 32'h7, {29'h0, ceq});
        rc(8'h3C, 32'h0, "unmapped");
        chk("pslverr", 32'h1, {31'h0, er});
        wr(LATCH_BASE + 8'h04, 32'h5);
        rc(LATCH_BASE + 8'h04, 32'h0, "latch1");
        $display("test reset finished");
        for (int i = 0; i < 4; i++)
        begin
            cfg = cw(2'(i), 2'b00, 2'b00, 6'h0);
            wr(CONTROL_OFFSET, cfg);
            wr(COUNT_OFFSET, 32'hFFFF_FFFF);
            rc(COUNT_OFFSET, {16'h0, ceil_t[i]}, "masked count");
            wr(COUNT_OFFSET, {16'h0, ceil_t[i] - 16'h1});
            go(MODE_CONTINUOUS, 3);
            rc(COUNT_OFFSET, 32'h1, "count past ceiling");
            rc(STATUS_OFFSET, 32'h2, "wrap");
            wr(STATUS_OFFSET, 32'h3);
        end
        $display("test lengths finished");
        for (int i = 0; i < 4; i++)
        begin
            sel = i;
            cfg = cw(2'b00, 2'b00, 2'(i), 6'h0);
            wr(CONTROL_OFFSET, cfg | 32'h1);
            go(MODE_CONTINUOUS, 2);
            rc(COUNT_OFFSET, 32'h2, "source count");
            go(MODE_STOP, 2);
            rc(COUNT_OFFSET, 32'h2, "halted count");
        end
        sel = 0;
        for (int d = 1; d < 4; d++)
        begin
            cfg = cw(2'b00, 2'(d), 2'b00, 6'h0);
            wr(CONTROL_OFFSET, cfg | 32'h1);
            go(MODE_CONTINUOUS, 8);
            rc(COUNT_OFFSET, 32'(8 >> d), "divided count");
        end
        $display("test clocks finished");
        cfg = cw(2'b00, 2'b00, 2'b00, 6'h0);
        wr(CONTROL_OFFSET, cfg | 32'h1);
        wr(BUFFER_BASE, 32'h3);
        rc(LATCH_BASE, 32'h3, "period latch");
        go(MODE_UP, 5);
        rc(COUNT_OFFSET, 32'h1, "up count");
        rc(STATUS_OFFSET, 32'h3, "up flags");
        wr(STATUS_OFFSET, 32'h3);
        wr(COUNT_OFFSET, 32'h3);
        rc(STATUS_OFFSET, 32'h0, "flags after write");
        wr(CONTROL_OFFSET, cw(2'b11, 2'b00, 2'b00, 6'h0));
        wr(BUFFER_BASE, 32'h1FF);
        wr(COUNT_OFFSET, 32'h5);
        cfg = cw(2'b11, 2'b00, 2'b00, 6'h0);
        go(MODE_UP, 1);
        rc(COUNT_OFFSET, 32'h0, "period above ceiling");
        cfg = cw(2'b00, 2'b00, 2'b00, 6'h0);
        wr(CONTROL_OFFSET, cfg);
        wr(BUFFER_BASE, 32'h0);
        wr(COUNT_OFFSET, 32'h2);
        go(MODE_UP, 2);
        rc(COUNT_OFFSET, 32'h2, "zero period hold");
        wr(BUFFER_BASE, 32'h4);
        go(MODE_UP, 1);
        rc(COUNT_OFFSET, 32'h0, "period restart");
        wr(COUNT_OFFSET, 32'h0);
        go(MODE_UP, 2);
        rc(COUNT_OFFSET, 32'h2, "count from zero");
        $display("test up mode finished");
        wr(CONTROL_OFFSET, cfg | 32'h1);
        wr(BUFFER_BASE, 32'h3);
        wr(STATUS_OFFSET, 32'h3);
        go(MODE_UP_DOWN, 5);
        rc(COUNT_OFFSET, 32'h1, "down count");
        rc(STATUS_OFFSET, 32'h5, "match and down");
        wr(STATUS_OFFSET, 32'h3);
        go(MODE_UP_DOWN, 2);
        rc(COUNT_OFFSET, 32'h1, "resumed down");
        rc(STATUS_OFFSET, 32'h2, "down wrap");
        wr(CONTROL_OFFSET, cfg | 32'h200);
        irqchk(1'b0);
        wr(CONTROL_OFFSET, cfg | 32'hA00);
        irqchk(1'b1);
        wr(STATUS_OFFSET, 32'h2);
        irqchk(1'b0);
        go(MODE_UP_DOWN, 3);
        wr(CONTROL_OFFSET, cfg | 32'h1);
        rc(COUNT_OFFSET, 32'h0, "cleared count");
        rc(STATUS_OFFSET, 32'h1, "direction cleared");
        $display("test up down finished");
        cfg = cw(2'b00, 2'b00, 2'b00, 6'h08);
        wr(CONTROL_OFFSET, cfg);
        wr(BUFFER_BASE + 8'h04, 32'h7);
        rc(LATCH_BASE + 8'h04, 32'h0, "latch waits");
        wr(COUNT_OFFSET, 32'hFFFE);
        go(MODE_CONTINUOUS, 3);
        rc(LATCH_BASE + 8'h04, 32'h7, "latch at zero");
        cfg = cw(2'b00, 2'b00, 2'b00, 6'h20);
        wr(CONTROL_OFFSET, cfg);
        wr(BUFFER_BASE + 8'h04, 32'h9);
        rc(LATCH_BASE + 8'h04, 32'h7, "group waits");
        wr(BUFFER_BASE + 8'h08, 32'h9);
        wr(BUFFER_BASE, 32'h9);
        rc(LATCH_BASE + 8'h04, 32'h9, "group loads");
        wr(COUNT_OFFSET, 32'h9);
        rc(COUNT_OFFSET, 32'h9, "count");
        chk("compare_equal", 32'h7, {29'h0, ceq});
        // load at turnaround: channel 2 must wait for the top of the up/down ramp
        cfg = cw(2'b00, 2'b00, 2'b00, 6'h10);
        wr(CONTROL_OFFSET, cfg);
        wr(COUNT_OFFSET, 32'h0);
        wr(BUFFER_BASE + 8'h08, 32'h5);
        rc(LATCH_BASE + 8'h08, 32'h9, "turn waits");
        go(MODE_UP_DOWN, 10);
        rc(LATCH_BASE + 8'h08, 32'h5, "latch at turn");
        $display("test latches finished");
        final_report;
    end
endmodule
`default_nettype wire
